// *** logic/omsw_top.v ***
// Operating mode switch logic: resolves panel, external, network or combined mode.
// Assumes AXI4-Lite software access on aclk and asynchronous terminal pins.
//
// Operation
// - Selector 0,2: network switch inputs move to network only when stopped.
// - Selector 6: switching input changes are accepted while running.
// - Net-panel configured: input on gives panel, off gives network.
// - Startup 10: selector 1 panel, 2 network, 3/4 combined, input ignored.
// - Net-panel on with net-external on yields network, not panel.
// - Selector 7 without net-external assigned: net-panel network result becomes panel/external from panel-external input.
// - Selector 7: interlock off forces external; on permits switching.
// - Selector 2, net-external configured, startup not 10: on gives network, off gives external.
// - Startup 0/1 with selector 2: only network or external, never panel.
// - Selector 0,6,7, net-external off: net-panel if assigned, else startup 10 gives network, else panel-external.
// - Priority: selector, interlock, net-external, net-panel, startup, panel-external; selector 2 checks startup before net-external.
// - After reset: both parameters are back at 0, so the first mode is external.
// - Selector accepts 0-4, 6, 7; both parameters reset to 0.
// - Selector and startup writes accepted regardless of write selection.
// - Selector 0,6,7: panel-external input toggles modes, stopped unless 6.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "omsw_map.vh"
module omsw_top (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Terminal pins
	input  wire        net_panel_switch_in,
	input  wire        net_external_switch_in,
	input  wire        panel_external_switch_in,
	input  wire        panel_interlock_in,
	input  wire        motor_running_in,
	input  wire        start_cmd_in,
	// Resolved mode
	output reg  [1:0]  mode_out,
	output reg         output_stop_out
);
	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	wire [5:0] pins_s;
	omsw_sync #(.WIDTH(6)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({start_cmd_in, motor_running_in, panel_interlock_in,
		            panel_external_switch_in, net_external_switch_in,
		            net_panel_switch_in}),
		.sync_out (pins_s)
	);
	wire np_s  = pins_s[0];
	wire ne_s  = pins_s[1];
	wire pe_s  = pins_s[2];
	wire il_s  = pins_s[3];
	wire stopped = !pins_s[4] || !pins_s[5];
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [3:0]  mode_select_param_r;
	reg  [3:0]  comm_startup_param_r;
	reg  [1:0]  assign_r;
	reg  [1:0]  param_write_select_r;
	reg  [11:0] awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg         aw_have_r;
	reg         w_have_r;
	reg         boot_r;
	wire        np_asn = assign_r[`OMSW_ASN_NET_PANEL];
	wire        ne_asn = assign_r[`OMSW_ASN_NET_EXT];
	function legal_sel;
		input [3:0] v;
		begin
			legal_sel = (v <= 4'h4) || (v == 4'h6) || (v == 4'h7);
		end
	endfunction
	// ------------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------------
	wire aw_now  = aw_have_r || (s_axi_awvalid && s_axi_awready);
	wire w_now   = w_have_r || (s_axi_wvalid && s_axi_wready);
	wire [11:0] wa = aw_have_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wd = w_have_r ? wdata_r : s_axi_wdata;
	wire [3:0]  ws = w_have_r ? wstrb_r : s_axi_wstrb;
	wire [11:0] wa_w = {wa[11:2], 2'b00};
	wire do_wr  = aw_now && w_now && !s_axi_bvalid;
	wire wr_sel = (wa_w == `OMSW_REG_MODE_SEL);
	wire wr_st  = (wa_w == `OMSW_REG_STARTUP);
	wire wr_asn = (wa_w == `OMSW_REG_ASSIGN);
	wire wr_ws  = (wa_w == `OMSW_REG_WRITE_SEL);
	wire wr_sta = (wa_w == `OMSW_REG_STATUS);
	wire st_ok  = (wd[3:0] == `OMSW_STARTUP_RST) || (wd[3:0] == 4'h1) ||
	              (wd[3:0] == `OMSW_STARTUP_NET);
	reg  wr_ok;
	always @* begin
		wr_ok = 1'b1;
		if (wr_sel)
			wr_ok = legal_sel(wd[3:0]);
		else if (wr_st)
			wr_ok = st_ok;
		else if (!(wr_asn || wr_ws || wr_sta))
			wr_ok = 1'b0;
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready        <= 1'b0;
			s_axi_wready         <= 1'b0;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `OMSW_RESP_OKAY;
			aw_have_r            <= 1'b0;
			w_have_r             <= 1'b0;
			awaddr_r             <= 12'h000;
			wdata_r              <= 32'h00000000;
			wstrb_r              <= 4'h0;
			mode_select_param_r  <= `OMSW_MODE_SEL_RST;
			comm_startup_param_r <= `OMSW_STARTUP_RST;
			assign_r             <= `OMSW_ASSIGN_RST;
			param_write_select_r <= `OMSW_WSEL_RST;
		end else begin
			s_axi_awready <= !aw_now && !s_axi_awready;
			s_axi_wready  <= !w_now && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_wr) begin
				aw_have_r     <= 1'b0;
				w_have_r      <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= wr_ok ? `OMSW_RESP_OKAY : `OMSW_RESP_SLVERR;
				// Write selection deliberately does not gate these two.
				if (ws[0] && wr_ok && wr_sel)
					mode_select_param_r <= wd[3:0];
				if (ws[0] && wr_ok && wr_st)
					comm_startup_param_r <= wd[3:0];
				if (ws[0] && wr_asn)
					assign_r <= wd[1:0];
				if (ws[0] && wr_ws)
					param_write_select_r <= wd[1:0];
			end
		end
	end
	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `OMSW_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `OMSW_RESP_OKAY;
				case ({s_axi_araddr[11:2], 2'b00})
				`OMSW_REG_MODE_SEL:
					s_axi_rdata <= {28'h0000000, mode_select_param_r};
				`OMSW_REG_STARTUP:
					s_axi_rdata <= {28'h0000000, comm_startup_param_r};
				`OMSW_REG_ASSIGN:
					s_axi_rdata <= {30'h0, assign_r};
				`OMSW_REG_STATUS:
					s_axi_rdata <= {24'h000000, 1'b0, output_stop_out,
					                pins_s[3:0], mode_out};
				`OMSW_REG_WRITE_SEL:
					s_axi_rdata <= {30'h0, param_write_select_r};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `OMSW_RESP_SLVERR;
				end
				endcase
			end
		end
	end
	// ------------------------------------------------------------------
	// Mode resolution
	// ------------------------------------------------------------------
	// Requested mode from the parameters and switch inputs, ignoring the
	// stopped condition; the sequencer below decides when it may be taken.
	wire st_net = (comm_startup_param_r == `OMSW_STARTUP_NET);
	wire [1:0] pe_mode = pe_s ? `OMSW_MODE_EXT : `OMSW_MODE_PANEL;
	reg  [1:0] req;
	reg        free_sel;
	always @* begin
		req = `OMSW_MODE_EXT;
		// Evaluation order follows the priority chain top-down.
		case (mode_select_param_r)
		4'h1: req = `OMSW_MODE_PANEL;
		4'h3, 4'h4: req = `OMSW_MODE_COMB;
		4'h2: begin
			if (st_net)
				req = `OMSW_MODE_NET;
			else if (ne_asn && ne_s)
				req = `OMSW_MODE_NET;
			else
				req = `OMSW_MODE_EXT;
		end
		default: begin
			if (mode_select_param_r == 4'h7 && !il_s)
				req = `OMSW_MODE_EXT;
			else if (ne_asn && ne_s)
				req = `OMSW_MODE_NET;
			else if (np_asn && !(ne_asn && ne_s))
				req = np_s ? `OMSW_MODE_PANEL : `OMSW_MODE_NET;
			else if (st_net && !np_asn)
				req = `OMSW_MODE_NET;
			else
				req = pe_mode;
			if (req == `OMSW_MODE_NET && np_asn && !np_s && !ne_asn
			    && mode_select_param_r == 4'h7)
				req = pe_mode;
		end
		endcase
		free_sel = (mode_select_param_r == 4'h6);
	end
	// Changes are taken only while stopped unless the selector is 6; fixed
	// modes and the forced external interlock apply at once.
	wire forced = (mode_select_param_r == 4'h7 && !il_s) ||
	              (mode_select_param_r == 4'h1) || (mode_select_param_r == 4'h3) ||
	              (mode_select_param_r == 4'h4);
	// A reset starts from the selector's own mode; the switch inputs only act afterwards.
	wire [1:0] boot_mode = (mode_select_param_r == 4'h1) ? `OMSW_MODE_PANEL :
	                       ((mode_select_param_r == 4'h3) || (mode_select_param_r == 4'h4)) ?
	                       `OMSW_MODE_COMB : (st_net && !forced) ? `OMSW_MODE_NET : `OMSW_MODE_EXT;
	always @(posedge aclk) begin
		if (!aresetn) begin
			boot_r          <= 1'b1;
			mode_out        <= `OMSW_MODE_EXT;
			output_stop_out <= 1'b0;
		end else begin
			boot_r <= 1'b0;
			if (boot_r)
				mode_out <= boot_mode;
			else if (forced || free_sel || stopped)
				mode_out <= req;
			output_stop_out <= (mode_select_param_r == 4'h7) && il_s &&
			                   (mode_out == `OMSW_MODE_EXT);
		end
	end
endmodule

// *** logic/omsw_map.vh ***
// Constants for the operating mode switch logic.
// Assumes inclusion by logic/omsw_top.v and the bench; definitions only.
`ifndef OMSW_MAP_VH
`define OMSW_MAP_VH
// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OMSW_REG_MODE_SEL    12'h000
`define OMSW_REG_STARTUP     12'h004
`define OMSW_REG_ASSIGN      12'h008
`define OMSW_REG_STATUS      12'h00C
`define OMSW_REG_WRITE_SEL   12'h010
// ------------------------------------------------------------------
// Reset values and legal settings
// ------------------------------------------------------------------
`define OMSW_MODE_SEL_RST    4'h0
`define OMSW_STARTUP_RST     4'h0
`define OMSW_STARTUP_NET     4'hA
`define OMSW_ASSIGN_RST      2'h0
`define OMSW_WSEL_RST        2'h0
// ------------------------------------------------------------------
// Assignment register fields
// ------------------------------------------------------------------
`define OMSW_ASN_NET_PANEL   0
`define OMSW_ASN_NET_EXT     1
// ------------------------------------------------------------------
// Mode encoding on mode_out
// ------------------------------------------------------------------
`define OMSW_MODE_EXT        2'h0
`define OMSW_MODE_PANEL      2'h1
`define OMSW_MODE_NET        2'h2
`define OMSW_MODE_COMB       2'h3
// ------------------------------------------------------------------
// Bus response codes
// ------------------------------------------------------------------
`define OMSW_RESP_OKAY       2'h0
`define OMSW_RESP_SLVERR     2'h2
`endif

// *** logic/omsw_sync.v ***
// Two-flop synchroniser bank for the terminal inputs.
// Assumes the inputs are asynchronous levels from pins.
`timescale 1ns/1ns
module omsw_sync #(
	parameter WIDTH = 6
) (
	// Clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// Levels
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end else begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_r;
endmodule

// *** tb/omsw_asserts.sv ***
// Checker bound to omsw_top: write replies and the settled operating mode.
// Assumes only the ports of omsw_top and the constants of omsw_map.vh.
`timescale 1ns/1ns
`include "omsw_map.vh"
module omsw_asserts (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Write channels
	input wire [11:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// Pins and mode
	input wire        net_panel_switch_in,
	input wire        net_external_switch_in,
	input wire        panel_external_switch_in,
	input wire        panel_interlock_in,
	input wire        motor_running_in,
	input wire        start_cmd_in,
	input wire [1:0]  mode_out,
	input wire        output_stop_out
);
	reg  [11:0] adr_r;
	reg  [3:0]  dat_r;
	reg  [3:0]  sel_r;
	reg  [3:0]  quiet_r;
	reg  [5:0]  pins_r;
	wire [5:0]  pins = {start_cmd_in, motor_running_in, panel_interlock_in,
		panel_external_switch_in, net_external_switch_in, net_panel_switch_in};
	wire        calm = quiet_r[2];
	wire        sel_wr = s_axi_bvalid & (adr_r == `OMSW_REG_MODE_SEL);
	wire        bad_sel = (dat_r == 4'h5) | dat_r[3];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Mode checks wait for four quiet cycles so sync and update delays never count.
	always @(posedge aclk) begin
		pins_r <= pins;
		if (s_axi_awvalid & s_axi_awready) adr_r <= s_axi_awaddr;
		if (s_axi_wvalid & s_axi_wready) dat_r <= s_axi_wdata[3:0];
		if (!aresetn) sel_r <= 4'h0;
		else if (sel_wr & s_axi_bready & (s_axi_bresp == `OMSW_RESP_OKAY)) sel_r <= dat_r;
		if (!aresetn | s_axi_awvalid | s_axi_wvalid | s_axi_bvalid | (pins != pins_r))
			quiet_r <= 4'h0;
		else if (!calm) quiet_r <= quiet_r + 4'h1;
	end
	a_fixed_panel: assert property (calm && sel_r == 4'h1 |-> mode_out == `OMSW_MODE_PANEL)
		else $error("selector 1 not panel");
	a_fixed_comb: assert property (calm && (sel_r == 4'h3 || sel_r == 4'h4)
		|-> mode_out == `OMSW_MODE_COMB) else $error("selector 3 or 4 not combined");
	a_force_ext: assert property (calm && sel_r == 4'h7 && !panel_interlock_in
		|-> mode_out == `OMSW_MODE_EXT && !output_stop_out) else $error("interlock not forced");
	a_stop_ext: assert property (calm && output_stop_out
		|-> mode_out == `OMSW_MODE_EXT && sel_r == 4'h7 && panel_interlock_in)
		else $error("output stop without cause");
	a_never_panel: assert property (calm && sel_r == 4'h2 |-> mode_out != `OMSW_MODE_PANEL)
		else $error("selector 2 gave panel");
	a_mode_settled: assert property (calm |=> $stable(mode_out) && $stable(output_stop_out))
		else $error("mode moved without cause");
	a_bad_refused: assert property (sel_wr && bad_sel |-> s_axi_bresp == `OMSW_RESP_SLVERR)
		else $error("illegal selector accepted");
	a_sel_taken: assert property (sel_wr && !bad_sel |-> s_axi_bresp == `OMSW_RESP_OKAY)
		else $error("legal selector refused");
	c_stop: cover property (output_stop_out);
	c_net: cover property (mode_out == `OMSW_MODE_NET);
	c_refused: cover property (s_axi_bvalid && s_axi_bresp == `OMSW_RESP_SLVERR);
endmodule
bind omsw_top omsw_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .net_panel_switch_in, .net_external_switch_in,
	.panel_external_switch_in, .panel_interlock_in, .motor_running_in, .start_cmd_in,
	.mode_out, .output_stop_out);

// *** tb/omsw_pins.sv ***
// Terminal side model: switch pins and motor state lines.
// Assumes the bench sets wanted levels; pins follow at the next edge.
`timescale 1ns/1ns
module omsw_pins (
	// Clock and wanted levels
	input  wire       aclk,
	input  wire [5:0] want,
	// Pin levels
	output reg        net_panel_switch_in,
	output reg        net_external_switch_in,
	output reg        panel_external_switch_in,
	output reg        panel_interlock_in,
	output reg        motor_running_in,
	output reg        start_cmd_in
);
	always @(posedge aclk) begin
		{start_cmd_in, motor_running_in, panel_interlock_in, panel_external_switch_in,
			net_external_switch_in, net_panel_switch_in} <= want;
	end
endmodule

// *** tb/tb_top.sv ***
// Bench for omsw_top: register access over AXI4-Lite and pin driven mode checks.
// Assumes omsw_map.vh and the omsw_pins model; pin bits are start,run,il,pe,ne,np.
`timescale 1ns/1ns
`include "omsw_map.vh"
module tb_top;
	reg         aclk = 1'h0;
	reg         aresetn = 1'h0;
	reg  [11:0] s_axi_awaddr = 12'h000;
	reg  [11:0] s_axi_araddr = 12'h000;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hF;
	reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg  [5:0]  want = 6'h00;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, mode_out;
	wire [31:0] s_axi_rdata;
	wire        output_stop_out, net_panel_switch_in, net_external_switch_in;
	wire        panel_external_switch_in, panel_interlock_in, motor_running_in, start_cmd_in;
	integer     err_total = 0;
	integer     n_tests = 0;
	integer     cyc = 0;
	always #20 aclk = ~aclk;
	omsw_pins u_pins (.aclk, .want, .net_panel_switch_in, .net_external_switch_in,
		.panel_external_switch_in, .panel_interlock_in, .motor_running_in, .start_cmd_in);
	omsw_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .net_panel_switch_in,
		.net_external_switch_in, .panel_external_switch_in, .panel_interlock_in,
		.motor_running_in, .start_cmd_in, .mode_out, .output_stop_out);
	task report_and_stop;
		begin
			if (err_total == 0 && n_tests > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		reg done;
		begin
			@(posedge aclk);
			done = 1'h0;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			while (!done) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wready) s_axi_wvalid <= 1'h0;
				if (s_axi_bvalid) begin
					s_axi_bready <= 1'h0;
					done = 1'h1;
					chk(s_axi_bresp, er);
				end
			end
		end
	endtask
	task rd(input [11:0] a, input [31:0] ed);
		reg done;
		begin
			@(posedge aclk);
			done = 1'h0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			while (!done) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'h0;
				if (s_axi_rvalid) begin
					s_axi_rready <= 1'h0;
					done = 1'h1;
					chk(s_axi_rdata, ed);
				end
			end
		end
	endtask
	task cfg(input [3:0] s, input [3:0] t, input [1:0] asn);
		begin
			wr(`OMSW_REG_STARTUP, t, `OMSW_RESP_OKAY);
			wr(`OMSW_REG_ASSIGN, asn, `OMSW_RESP_OKAY);
			wr(`OMSW_REG_MODE_SEL, s, `OMSW_RESP_OKAY);
		end
	endtask
	// Pins are set, then the mode is read once sync and update delays are over.
	task mchk(input [5:0] p, input [1:0] em, input es);
		begin
			@(posedge aclk);
			want <= p;
			repeat (8) @(posedge aclk);
			chk({output_stop_out, mode_out}, {es, em});
		end
	endtask
	task t_regs;
		begin
			rd(`OMSW_REG_MODE_SEL, 32'h0);
			rd(`OMSW_REG_STARTUP, 32'h0);
			wr(`OMSW_REG_MODE_SEL, 32'h5, `OMSW_RESP_SLVERR);
			wr(12'h020, 32'h1, `OMSW_RESP_SLVERR);
			rd(`OMSW_REG_MODE_SEL, 32'h0);
			wr(`OMSW_REG_WRITE_SEL, 32'h1, `OMSW_RESP_OKAY);
			wr(`OMSW_REG_STARTUP, 32'h1, `OMSW_RESP_OKAY);
			rd(`OMSW_REG_STARTUP, 32'h1);
		end
	endtask
	task t_fixed;
		begin
			cfg(4'h1, 4'hA, 2'h1);
			mchk(6'h01, `OMSW_MODE_PANEL, 1'h0);
			wr(`OMSW_REG_MODE_SEL, 32'h3, `OMSW_RESP_OKAY);
			mchk(6'h01, `OMSW_MODE_COMB, 1'h0);
			wr(`OMSW_REG_MODE_SEL, 32'h4, `OMSW_RESP_OKAY);
			mchk(6'h00, `OMSW_MODE_COMB, 1'h0);
			wr(`OMSW_REG_MODE_SEL, 32'h2, `OMSW_RESP_OKAY);
			mchk(6'h01, `OMSW_MODE_NET, 1'h0);
		end
	endtask
	task t_links;
		begin
			cfg(4'h0, 4'hA, 2'h3);
			mchk(6'h01, `OMSW_MODE_PANEL, 1'h0);
			mchk(6'h03, `OMSW_MODE_NET, 1'h0);
			cfg(4'h2, 4'h0, 2'h2);
			mchk(6'h02, `OMSW_MODE_NET, 1'h0);
			mchk(6'h04, `OMSW_MODE_EXT, 1'h0);
			mchk(6'h00, `OMSW_MODE_EXT, 1'h0);
		end
	endtask
	task t_interlock;
		begin
			cfg(4'h7, 4'h0, 2'h2);
			mchk(6'h06, `OMSW_MODE_EXT, 1'h0);
			mchk(6'h0C, `OMSW_MODE_EXT, 1'h1);
			mchk(6'h0E, `OMSW_MODE_NET, 1'h0);
			cfg(4'h7, 4'hA, 2'h1);
			mchk(6'h08, `OMSW_MODE_PANEL, 1'h0);
			mchk(6'h0C, `OMSW_MODE_EXT, 1'h1);
		end
	endtask
	// Mid-run reset: the first mode after release comes from the reset selector.
	task t_reset;
		begin
			@(posedge aclk);
			aresetn <= 1'h0;
			@(posedge aclk);
			aresetn <= 1'h1;
			repeat (2) @(posedge aclk);
			chk(mode_out, `OMSW_MODE_EXT);
			rd(`OMSW_REG_MODE_SEL, 32'h0);
			rd(`OMSW_REG_STARTUP, 32'h0);
		end
	endtask
	task t_running;
		begin
			cfg(4'h0, 4'h1, 2'h2);
			mchk(6'h04, `OMSW_MODE_EXT, 1'h0);
			mchk(6'h36, `OMSW_MODE_EXT, 1'h0);
			wr(`OMSW_REG_MODE_SEL, 32'h6, `OMSW_RESP_OKAY);
			mchk(6'h36, `OMSW_MODE_NET, 1'h0);
		end
	endtask
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_fixed;
		t_links;
		t_interlock;
		t_running;
		t_reset;
		report_and_stop;
	end
endmodule
